// [hdl/cis_pkg.sv]
// Package of constants and types for the CPU interrupt sequencer.
// Behaviour
// - Any reset leaves interrupts disabled.
// - Divert only with global and individual enable.
// - Peripheral sources also need peripheral-group enable.
// - Flags set regardless of any enable.
// - Take: flush, clear global, push, save, vector.
// - Global clear: events only set flags.
// - Pending interrupt serviced once global set again.
// - Return pops PC, restores context, sets global.
// - Synchronous events reach vector in three-four cycles.
// - Asynchronous events reach vector in three-five cycles.
`default_nettype none
package cis_pkg;

    // ========================================================================
    // Constants
    localparam int PC_W = 15;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h0004;
    localparam logic GIE_RESET = 1'h0;
    localparam logic FLAG_RESET = 1'h0;
    localparam int TAKE_STEPS = 3;

    // ========================================================================
    // Types
    typedef enum logic [3:0] {
        CIS_RUN = 4'h1,
        CIS_FLUSH = 4'h2,
        CIS_SAVE = 4'h4,
        CIS_VECTOR = 4'h8
    } cis_state_t;

    typedef struct packed {
        logic flush;
        logic push_pc;
        logic save_ctx;
        logic load_pc;
        logic pop_pc;
        logic restore_ctx;
    } cis_core_ctl_t;

endpackage
`default_nettype wire

// [hdl/cis_flag_bank.sv]
// Per-source sticky interrupt flags.
`timescale 1ns/1ns
`default_nettype none
module cis_flag_bank #(
    parameter int N_SRC = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Events and clears
    input wire logic [N_SRC-1:0] event_i,
    input wire logic [N_SRC-1:0] clear_i,
    // Flags
    output logic [N_SRC-1:0] flag_o
);

    // ========================================================================
    // Flags
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++)
        begin : g_flag
            logic flag_q;
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    flag_q <= cis_pkg::FLAG_RESET;
                else if (event_i[g])
                    flag_q <= 1'h1;
                else if (clear_i[g])
                    flag_q <= 1'h0;
            end
            assign flag_o[g] = flag_q;
        end
    endgenerate

endmodule
`default_nettype wire

// [hdl/cpu_interrupt_sequencer.sv]
// Interrupt sequencer that diverts the core to the shared vector.
`timescale 1ns/1ns
`default_nettype none
module cis_cpu_interrupt_sequencer #(
    parameter int N_SRC = 8,
    parameter logic [N_SRC-1:0] PERIPH_MASK = {N_SRC{1'b1}}
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Instruction cycle strobe from the core
    input wire logic instr_cycle_i,
    // Interrupt sources
    input wire logic [N_SRC-1:0] src_event_i,
    input wire logic [N_SRC-1:0] src_enable_i,
    input wire logic periph_group_irq_enable_i,
    // Firmware access
    input wire logic [N_SRC-1:0] flag_clear_i,
    input wire logic global_irq_enable_wr_i,
    input wire logic global_irq_enable_wdata_i,
    input wire logic return_from_irq_instr_i,
    // Status
    output logic [N_SRC-1:0] irq_flag_o,
    output logic global_irq_enable_o,
    output logic irq_pending_o,
    output logic in_service_o,
    // Core control
    output cis_pkg::cis_core_ctl_t core_ctl_o,
    output logic [cis_pkg::PC_W-1:0] vector_pc_o
);

    // ========================================================================
    // Parameter check
    generate
        if (N_SRC < 1 || N_SRC > 64)
        begin : g_bad
            $error("N_SRC must lie between 1 and 64.");
        end
    endgenerate

    // ========================================================================
    // Flags
    logic [N_SRC-1:0] flag_w;
    logic [N_SRC-1:0] flag_q;

    cis_flag_bank #(
        .N_SRC(N_SRC)
    ) u_flags (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .event_i(src_event_i),
        .clear_i(flag_clear_i),
        .flag_o(flag_w)
    );

    // ========================================================================
    // Request forming
    logic [N_SRC-1:0] group_ok_w;
    logic [N_SRC-1:0] src_req_w;
    logic any_req_w;
    logic gie_q;
    logic gie_d;
    logic take_w;

    assign group_ok_w = ~PERIPH_MASK | {N_SRC{periph_group_irq_enable_i}};
    assign src_req_w = flag_q & src_enable_i & group_ok_w;
    assign any_req_w = |src_req_w;

    // ========================================================================
    // Sequencer
    cis_pkg::cis_state_t state_q;
    cis_pkg::cis_state_t state_d;
    logic in_service_q;
    logic in_service_d;
    cis_pkg::cis_core_ctl_t ctl_q;
    cis_pkg::cis_core_ctl_t ctl_d;
    logic ret_w;

    // Pending requests wait here while the global enable is clear.
    assign take_w = instr_cycle_i && gie_q && any_req_w
                    && (state_q == cis_pkg::CIS_RUN);
    assign ret_w = return_from_irq_instr_i && (state_q == cis_pkg::CIS_RUN);

    always_comb
    begin
        state_d = state_q;
        in_service_d = in_service_q;
        ctl_d = '0;
        case (state_q)
            cis_pkg::CIS_RUN:
            begin
                if (take_w)
                begin
                    state_d = cis_pkg::CIS_FLUSH;
                    ctl_d.flush = 1'h1;
                end
                else if (ret_w)
                begin
                    in_service_d = 1'h0;
                    ctl_d.pop_pc = 1'h1;
                    ctl_d.restore_ctx = 1'h1;
                end
            end
            cis_pkg::CIS_FLUSH:
            begin
                if (instr_cycle_i)
                begin
                    state_d = cis_pkg::CIS_SAVE;
                    ctl_d.push_pc = 1'h1;
                    ctl_d.save_ctx = 1'h1;
                end
            end
            cis_pkg::CIS_SAVE:
            begin
                if (instr_cycle_i)
                begin
                    state_d = cis_pkg::CIS_VECTOR;
                    ctl_d.load_pc = 1'h1;
                end
            end
            cis_pkg::CIS_VECTOR:
            begin
                state_d = cis_pkg::CIS_RUN;
                in_service_d = 1'h1;
            end
            default:
            begin
                state_d = cis_pkg::CIS_RUN;
            end
        endcase
    end

    // ========================================================================
    // Global enable
    always_comb
    begin
        gie_d = gie_q;
        if (global_irq_enable_wr_i)
            gie_d = global_irq_enable_wdata_i;
        if (ret_w && !take_w)
            gie_d = 1'h1;
        if (take_w)
            gie_d = 1'h0;
    end

    // ========================================================================
    // Registers
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            gie_q <= cis_pkg::GIE_RESET;
            state_q <= cis_pkg::CIS_RUN;
            in_service_q <= 1'h0;
            ctl_q <= '0;
            flag_q <= '0;
        end
        else
        begin
            gie_q <= gie_d;
            state_q <= state_d;
            in_service_q <= in_service_d;
            ctl_q <= ctl_d;
            flag_q <= flag_w;
        end
    end

    // ========================================================================
    // Outputs
    logic pending_q;
    logic [cis_pkg::PC_W-1:0] vector_q;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pending_q <= 1'h0;
            vector_q <= cis_pkg::IRQ_VECTOR;
        end
        else
        begin
            pending_q <= any_req_w;
            vector_q <= cis_pkg::IRQ_VECTOR;
        end
    end

    assign irq_flag_o = flag_q;
    assign global_irq_enable_o = gie_q;
    assign irq_pending_o = pending_q;
    assign in_service_o = in_service_q;
    assign core_ctl_o = ctl_q;
    assign vector_pc_o = vector_q;

endmodule
`default_nettype wire

// [tb/cis_seq_asserts.sv]
// Port checker for the interrupt sequencer.
`timescale 1ns/1ns
`default_nettype none
module cis_seq_chk #(parameter int N_SRC = 8) (
    // Ports watched
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [N_SRC-1:0] src_event_i,
    input wire logic [N_SRC-1:0] irq_flag_o,
    input wire logic global_irq_enable_o,
    input wire logic in_service_o,
    input wire cis_pkg::cis_core_ctl_t core_ctl_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    reset_off_a: assert property (disable iff (1'b0) !resetn_i |-> !global_irq_enable_o && core_ctl_o == '0)
        else $error("reset left outputs active");
    take_needs_gie_a: assert property ($rose(core_ctl_o.flush) |-> $past(global_irq_enable_o))
        else $error("take without global enable");
    flush_clears_gie_a: assert property (core_ctl_o.flush |-> !global_irq_enable_o)
        else $error("global enable kept on take");
    push_after_flush_a: assert property (core_ctl_o.flush |-> ##[1:8] (core_ctl_o.push_pc && core_ctl_o.save_ctx))
        else $error("push late");
    load_after_push_a: assert property (core_ctl_o.push_pc |-> ##[1:8] core_ctl_o.load_pc ##1 in_service_o)
        else $error("vector load late");
    return_restores_a: assert property (core_ctl_o.pop_pc |-> core_ctl_o.restore_ctx && global_irq_enable_o && !in_service_o)
        else $error("return incomplete");
    event_flag_a: assert property (|src_event_i |-> ##2 (irq_flag_o & $past(src_event_i, 2)) == $past(src_event_i, 2))
        else $error("flag not set");
    no_flush_busy_a: assert property (in_service_o |-> !core_ctl_o.flush)
        else $error("take during service");
    cover property (core_ctl_o.flush);
    cover property (core_ctl_o.pop_pc);
    cover property (|src_event_i);
endmodule
bind cis_cpu_interrupt_sequencer cis_seq_chk #(.N_SRC(N_SRC)) u_chk (.clk_i, .resetn_i,
    .src_event_i, .irq_flag_o, .global_irq_enable_o, .in_service_o, .core_ctl_o);
`default_nettype wire

// [tb/cis_core_model.sv]
// Core model: instruction strobe and service routine firmware.
`timescale 1ns/1ns
`default_nettype none
module cis_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Speed select from bench, status from sequencer
    input wire logic slow_i,
    input wire logic in_service_i,
    input wire logic [7:0] irq_flag_i,
    // Core side
    output logic instr_cycle_o,
    output logic [7:0] flag_clear_o,
    output logic return_o
);
    int ph = 0;
    initial {instr_cycle_o, flag_clear_o, return_o} = '0;
    always @(negedge clk_i)
    begin
        ph = resetn_i ? (ph + 1) % 4 : 0;
        instr_cycle_o <= (ph == 3);
    end
    always @(posedge in_service_i)
    begin
        repeat (slow_i ? 20 : 2) @(negedge clk_i);
        flag_clear_o <= irq_flag_i;
        @(negedge clk_i) flag_clear_o <= '0;
        repeat (3) @(negedge clk_i);
        return_o <= 1'b1;
        @(negedge clk_i) return_o <= 1'b0;
    end
endmodule
`default_nettype wire

// [tb/cis_cpu_interrupt_sequencer_tb_top.sv]
// Self-checking bench for the interrupt sequencer.
`timescale 1ns/1ns
`default_nettype none
module cis_cpu_interrupt_sequencer_tb_top;
    localparam logic [7:0] MASK = 8'hF0;
    logic clk_i = 1'b0, resetn_i = 1'b1, gwr = 1'b0, gwd = 1'b0, pg = 1'b0, slow = 1'b0;
    logic ic, ret, global_irq_enable, ins, pend, gm = 1'b0;
    logic [7:0] ev = '0, en = '0, clr, flg, xf = '0;
    logic [14:0] vpc;
    cis_pkg::cis_core_ctl_t ctl;
    int mismatches = 0, checked = 0, takes = 0;
    cis_cpu_interrupt_sequencer #(.PERIPH_MASK(MASK)) dut (.clk_i, .resetn_i,
        .instr_cycle_i(ic), .src_event_i(ev), .src_enable_i(en),
        .periph_group_irq_enable_i(pg), .flag_clear_i(clr), .global_irq_enable_wr_i(gwr),
        .global_irq_enable_wdata_i(gwd), .return_from_irq_instr_i(ret), .irq_flag_o(flg),
        .global_irq_enable_o(global_irq_enable), .irq_pending_o(pend), .in_service_o(ins),
        .core_ctl_o(ctl), .vector_pc_o(vpc));
    cis_core_model core (.clk_i, .resetn_i, .slow_i(slow), .in_service_i(ins),
        .irq_flag_i(flg), .instr_cycle_o(ic), .flag_clear_o(clr), .return_o(ret));
    initial forever #2 clk_i = ~clk_i;
    // Takes are counted just after the launching edge, away from the stimulus edge.
    always @(posedge clk_i) #1 if (ctl.flush === 1'b1) takes++;
    // ========================================
    // Tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic step(input logic [7:0] e, input logic [7:0] n, input logic p, input logic g);
        int t;
        logic x;
        logic y;
        t = takes;
        @(negedge clk_i) {ev, en, pg, gwr, gwd} = {e, n, p, 1'b1, g};
        xf |= e;
        gm = g;
        @(negedge clk_i) {ev, gwr} = '0;
        repeat (2) @(negedge clk_i);
        check(flg, xf);
        y = |(xf & n & (~MASK | {8{p}}));
        x = gm && y;
        check({7'h0, pend}, {7'h0, y});
        repeat (40) @(negedge clk_i);
        check(8'(takes - t), {7'h0, x});
        for (int i = 0; i < 200 && x && ins !== 1'b0; i++) @(negedge clk_i);
        if (x)
        begin
            repeat (2) @(negedge clk_i);
            check({7'h0, global_irq_enable}, 8'h01);
            xf = '0;
        end
        $display("Step done: event %h enable %h", e, n);
    endtask
    // ========================================
    // Tests
    initial
    begin
        void'($urandom(32'h0AE0));
        #1 resetn_i = 1'b0;
        repeat (3) @(negedge clk_i);
        resetn_i = 1'b1;
        check({7'h0, global_irq_enable}, 8'h00);
        check(vpc[7:0], 8'h04);
        check({1'b0, vpc[14:8]}, 8'h00);
        step(8'h01, 8'h01, 1'b0, 1'b0);
        step(8'h00, 8'h01, 1'b0, 1'b1);
        step(8'h10, 8'h10, 1'b0, 1'b1);
        step(8'h00, 8'h10, 1'b1, 1'b1);
        for (int i = 0; i < 30; i++)
        begin
            slow = 1'($urandom);
            step(8'($urandom), 8'($urandom), 1'($urandom), 1'b1);
        end
        @(negedge clk_i) resetn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        check({7'h0, global_irq_enable}, 8'h00);
        check(flg, 8'h00);
        xf = '0;
        step(8'h02, 8'h02, 1'b0, 1'b1);
        print_verdict();
    end
    initial
    begin
        #200000;
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
